// [logic/irq_mask_pkg.sv]
package irq_mask_pkg;
    localparam int          DATA_W           = 32;
    localparam int          MASK_W           = 8;
    localparam int          SRC_N            = 4;
    // byte addresses of the bus registers
    localparam logic [11:0] ADDR_MASK        = 12'h000;
    localparam logic [11:0] ADDR_GLOBAL      = 12'h004;
    localparam logic [11:0] ADDR_PENDING     = 12'h008;
    localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h00C;
    localparam logic [11:0] ADDR_IRQ_ENABLE  = 12'h010;
    localparam logic [11:0] ADDR_IRQ_CLEAR   = 12'h014;
    // enable bit positions inside the mask register
    localparam int          BIT_TIMER        = 0;
    localparam int          BIT_PORT_CHANGE  = 1;
    localparam int          BIT_EXT_PIN      = 2;
    localparam logic [7:0]  MASK_IMPL        = 8'h07;
    localparam logic [7:0]  MASK_RESET       = 8'h00;
    // source index of the pending vector
    localparam int          SRC_TIMER        = 0;
    localparam int          SRC_PORT_CHANGE  = 1;
    localparam int          SRC_EXT0         = 2;
    localparam int          SRC_EXT1         = 3;
    // event status bits
    localparam int          EV_REQ_RISE      = 0;
    localparam int          EV_WAKE_RISE     = 1;
    localparam int          EV_W             = 2;
    localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
endpackage

// [logic/sticky_bit.sv]
`timescale 1ns/1ps
module sticky_bit
    import irq_mask_pkg::*;
(
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic set,
    input  wire logic clr,
    output logic      q
);
    typedef struct packed {
        logic q_r;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        // set wins over a clear in the same cycle
        if (clr) begin
            s_nxt.q_r = 1'b0;
        end
        if (set) begin
            s_nxt.q_r = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.q_r;
endmodule

// [logic/interrupt_enable_mask.sv]
// Local design decisions: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
// What this block does
// - mask register is read and written by software; reads return last written bits 2 to 0
// - a source is enabled only when software writes one to its bit
// - global enable set by on-instruction, cleared by off-instruction, gates the vector request of all sources but not the wake request
// - bits 7 to 3 read zero and ignore writes
// - bit 2 enables or disables both external pin pending flags together
// - port change wakes or vectors only while its enable bit is set
// - bit 0 lets timer overflow pending raise an interrupt
module interrupt_enable_mask
    import irq_mask_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [DATA_W-1:0] hwdata,
    input  wire logic              hready,
    output logic [DATA_W-1:0]      hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              global_irq_on_instr,
    input  wire logic              global_irq_off_instr,
    input  wire logic              ext_pin0_pending,
    input  wire logic              ext_pin1_pending,
    input  wire logic              port_change_pending,
    input  wire logic              timer_overflow_pending,
    output logic                   irq_vector_req,
    output logic                   wake_req,
    output logic                   global_irq_enable,
    output logic                   irq
);
    typedef struct packed {
        logic [MASK_W-1:0] mask_r;
        logic              gie_r;
        logic              wr_pend_r;
        logic [11:0]       addr_r;
        logic [DATA_W-1:0] rdata_r;
        logic              vec_r;
        logic              wake_r;
        logic [EV_W-1:0]   ev_en_r;
        logic              irq_r;
        logic              ready_r;
        logic              resp_r;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    logic [SRC_N-1:0] pend;
    logic [SRC_N-1:0] src_en;
    logic [SRC_N-1:0] gated;
    logic             any_req;
    logic             addr_ok;
    logic             rd_now;
    logic             wr_phase;
    logic [EV_W-1:0]  ev_set;
    logic [EV_W-1:0]  ev_clr;
    logic [EV_W-1:0]  ev_q;

    assign pend = {ext_pin1_pending, ext_pin0_pending,
                   port_change_pending, timer_overflow_pending};

    // per source enable view of the mask
    always_comb begin
        src_en                  = '0;
        src_en[SRC_TIMER]       = s_r.mask_r[BIT_TIMER];
        src_en[SRC_PORT_CHANGE] = s_r.mask_r[BIT_PORT_CHANGE];
        src_en[SRC_EXT0]        = s_r.mask_r[BIT_EXT_PIN];
        src_en[SRC_EXT1]        = s_r.mask_r[BIT_EXT_PIN];
    end

    assign gated   = pend & src_en;
    assign any_req = |gated;

    assign addr_ok  = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign rd_now   = addr_ok && !hwrite;
    assign wr_phase = s_r.wr_pend_r;

    // hardware events: rising edges of the two request outputs
    assign ev_set[EV_REQ_RISE]  = (any_req && s_r.gie_r) && !s_r.vec_r;
    assign ev_set[EV_WAKE_RISE] = any_req && !s_r.wake_r;
    assign ev_clr = (wr_phase && s_r.addr_r == ADDR_IRQ_CLEAR) ?
                    hwdata[EV_W-1:0] : '0;

    genvar g;
    generate
        for (g = 0; g < EV_W; g++) begin : g_ev
            sticky_bit u_sticky (
                .clk    (clk),
                .arst_n (arst_n),
                .set    (ev_set[g]),
                .clr    (ev_clr[g]),
                .q      (ev_q[g])
            );
        end
    endgenerate

    always_comb begin
        s_nxt           = s_r;
        s_nxt.wr_pend_r = addr_ok && hwrite;
        if (addr_ok) begin
            s_nxt.addr_r = haddr[11:0];
        end
        // register writes land in the data phase
        if (wr_phase) begin
            case (s_r.addr_r)
                ADDR_MASK: begin
                    s_nxt.mask_r = hwdata[MASK_W-1:0] & MASK_IMPL;
                end
                ADDR_IRQ_ENABLE: begin
                    s_nxt.ev_en_r = hwdata[EV_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // off wins if both arrive together, the safer choice
        if (global_irq_on_instr) begin
            s_nxt.gie_r = 1'b1;
        end
        if (global_irq_off_instr) begin
            s_nxt.gie_r = 1'b0;
        end
        // read data registered at the address phase, zero for unmapped
        // no forwarding: a read right after a write sees the old value
        if (rd_now) begin
            case (haddr[11:0])
                ADDR_MASK: begin
                    s_nxt.rdata_r = DATA_W'(s_r.mask_r);
                end
                ADDR_GLOBAL: begin
                    s_nxt.rdata_r = DATA_W'(s_r.gie_r);
                end
                ADDR_PENDING: begin
                    s_nxt.rdata_r = DATA_W'(pend);
                end
                ADDR_IRQ_STATUS: begin
                    s_nxt.rdata_r = DATA_W'(ev_q);
                end
                ADDR_IRQ_ENABLE: begin
                    s_nxt.rdata_r = DATA_W'(s_r.ev_en_r);
                end
                default: begin
                    s_nxt.rdata_r = '0;
                end
            endcase
        end
        // no wait states and no error response, so the master never stalls
        s_nxt.ready_r = 1'b1;
        s_nxt.resp_r  = 1'b0;
        s_nxt.vec_r  = any_req && s_r.gie_r;
        s_nxt.wake_r = any_req;
        s_nxt.irq_r  = |(ev_q & s_r.ev_en_r);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r         <= '0;
            s_r.mask_r  <= MASK_RESET;
            s_r.ready_r <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hrdata            = s_r.rdata_r;
    assign hreadyout         = s_r.ready_r;
    assign hresp             = s_r.resp_r;
    assign irq_vector_req    = s_r.vec_r;
    assign wake_req          = s_r.wake_r;
    assign global_irq_enable = s_r.gie_r;
    assign irq               = s_r.irq_r;

    // checks
    AST_MASK_WRITE: assert property (
        @(posedge clk) disable iff (!arst_n)
        s_r.wr_pend_r && (s_r.addr_r == ADDR_MASK)
        |=> s_r.mask_r == ($past(hwdata[MASK_W-1:0]) & MASK_IMPL))
        else $error("mask write not stored");

    AST_MASK_HOLD: assert property (
        @(posedge clk) disable iff (!arst_n)
        !(s_r.wr_pend_r && (s_r.addr_r == ADDR_MASK))
        |=> $stable(s_r.mask_r))
        else $error("mask changed without a write");

    AST_MASK_HIGH_ZERO: assert property (
        @(posedge clk) disable iff (!arst_n)
        (s_r.mask_r & ~MASK_IMPL) == '0)
        else $error("unimplemented mask bits set");

    AST_READ_MASK: assert property (
        @(posedge clk) disable iff (!arst_n)
        rd_now && (haddr[11:0] == ADDR_MASK)
        |=> hrdata == DATA_W'($past(s_r.mask_r)))
        else $error("mask read wrong");

    AST_READ_GLOBAL: assert property (
        @(posedge clk) disable iff (!arst_n)
        rd_now && (haddr[11:0] == ADDR_GLOBAL)
        |=> hrdata == DATA_W'($past(global_irq_enable)))
        else $error("global enable read wrong");

    AST_READ_PENDING: assert property (
        @(posedge clk) disable iff (!arst_n)
        rd_now && (haddr[11:0] == ADDR_PENDING)
        |=> hrdata == DATA_W'($past(pend)))
        else $error("pending read wrong");

    AST_READ_STATUS: assert property (
        @(posedge clk) disable iff (!arst_n)
        rd_now && (haddr[11:0] == ADDR_IRQ_STATUS)
        |=> hrdata == DATA_W'($past(ev_q)))
        else $error("status read wrong");

    AST_READ_ENABLE: assert property (
        @(posedge clk) disable iff (!arst_n)
        rd_now && (haddr[11:0] == ADDR_IRQ_ENABLE)
        |=> hrdata == DATA_W'($past(s_r.ev_en_r)))
        else $error("event enable read wrong");

    AST_READ_UNMAPPED: assert property (
        @(posedge clk) disable iff (!arst_n)
        rd_now && (haddr[11:0] == ADDR_IRQ_CLEAR)
        |=> hrdata == '0)
        else $error("write-only register read not zero");

    AST_BUS_OKAY: assert property (
        @(posedge clk) disable iff (!arst_n)
        hreadyout && !hresp)
        else $error("bus stalled or error response");

    AST_GIE_ON: assert property (
        @(posedge clk) disable iff (!arst_n)
        global_irq_on_instr && !global_irq_off_instr
        |=> global_irq_enable)
        else $error("global enable not set");

    AST_GIE_OFF: assert property (
        @(posedge clk) disable iff (!arst_n)
        global_irq_off_instr
        |=> !global_irq_enable ##1 !irq_vector_req)
        else $error("global disable not effective");

    AST_GIE_HOLD: assert property (
        @(posedge clk) disable iff (!arst_n)
        !global_irq_on_instr && !global_irq_off_instr
        |=> $stable(global_irq_enable))
        else $error("global enable changed without instruction");

    AST_EXT_BOTH: assert property (
        @(posedge clk) disable iff (!arst_n)
        (ext_pin0_pending || ext_pin1_pending) && s_r.mask_r[BIT_EXT_PIN]
        |=> wake_req)
        else $error("ext pending not passed");

    AST_EXT_BLOCK: assert property (
        @(posedge clk) disable iff (!arst_n)
        !s_r.mask_r[BIT_EXT_PIN] && !port_change_pending && !timer_overflow_pending
        |=> !wake_req)
        else $error("ext pending not blocked");

    AST_PORT_ON: assert property (
        @(posedge clk) disable iff (!arst_n)
        port_change_pending && s_r.mask_r[BIT_PORT_CHANGE]
        |=> wake_req)
        else $error("port change not passed");

    AST_PORT_BLOCK: assert property (
        @(posedge clk) disable iff (!arst_n)
        port_change_pending && !s_r.mask_r[BIT_PORT_CHANGE] && !ext_pin0_pending
        && !ext_pin1_pending && !timer_overflow_pending |=> !wake_req)
        else $error("port change not blocked");

    AST_TIMER_ON: assert property (
        @(posedge clk) disable iff (!arst_n)
        timer_overflow_pending && s_r.mask_r[BIT_TIMER] && s_r.gie_r
        |=> irq_vector_req)
        else $error("timer request lost");

    AST_TIMER_BLOCK: assert property (
        @(posedge clk) disable iff (!arst_n)
        timer_overflow_pending && !s_r.mask_r[BIT_TIMER] && !port_change_pending
        && !ext_pin0_pending && !ext_pin1_pending |=> !wake_req)
        else $error("timer overflow not blocked");

    AST_NO_ENABLE_NO_REQ: assert property (
        @(posedge clk) disable iff (!arst_n)
        s_r.mask_r == '0
        |=> !wake_req)
        else $error("request without enable");

    // every registered request lags its cause by exactly one edge
    AST_WAKE_LEVEL: assert property (
        @(posedge clk) disable iff (!arst_n)
        wake_req == $past(any_req))
        else $error("wake request wrong");

    AST_VEC_LEVEL: assert property (
        @(posedge clk) disable iff (!arst_n)
        irq_vector_req == $past(any_req && global_irq_enable))
        else $error("vector request wrong");

    // a held source latches its status once, on the rising edge only
    AST_STATUS_WAKE: assert property (
        @(posedge clk) disable iff (!arst_n)
        $rose(wake_req)
        |-> ev_q[EV_WAKE_RISE])
        else $error("wake status not set");

    AST_STATUS_VEC: assert property (
        @(posedge clk) disable iff (!arst_n)
        $rose(irq_vector_req)
        |-> ev_q[EV_REQ_RISE])
        else $error("vector status not set");

    AST_STATUS_CLEAR: assert property (
        @(posedge clk) disable iff (!arst_n)
        ev_clr[EV_WAKE_RISE] && !ev_set[EV_WAKE_RISE]
        |=> !ev_q[EV_WAKE_RISE])
        else $error("wake status not cleared");

    AST_IRQ_LEVEL: assert property (
        @(posedge clk) disable iff (!arst_n)
        irq == $past(|(ev_q & s_r.ev_en_r)))
        else $error("interrupt line wrong");

    // covers for the main scenarios
    COV_VECTOR: cover property (
        @(posedge clk) disable iff (!arst_n)
        $rose(irq_vector_req));

    COV_WAKE_NO_GIE: cover property (
        @(posedge clk) disable iff (!arst_n)
        wake_req && !global_irq_enable);

    COV_IRQ: cover property (
        @(posedge clk) disable iff (!arst_n)
        $rose(irq));

    COV_PORT_WAKE: cover property (
        @(posedge clk) disable iff (!arst_n)
        $rose(wake_req) && s_r.mask_r[BIT_PORT_CHANGE]);

    COV_GIE_BOTH: cover property (
        @(posedge clk) disable iff (!arst_n)
        global_irq_on_instr && global_irq_off_instr);
endmodule

// [testbench/irq_core_model.sv]
`timescale 1ns/1ps
module irq_core_model (
    input  wire logic  clk,
    output logic       global_irq_on_instr,
    output logic       global_irq_off_instr,
    output logic [3:0] pend
);
    initial begin
        global_irq_on_instr  = 1'b0;
        global_irq_off_instr = 1'b0;
        pend                 = 4'h0;
    end
    // one-cycle instruction pulse; code 3 issues both at once
    task automatic instr(input logic [1:0] code);
        @(posedge clk);
        global_irq_on_instr  <= code[0];
        global_irq_off_instr <= code[1];
        @(posedge clk);
        global_irq_on_instr  <= 1'b0;
        global_irq_off_instr <= 1'b0;
    endtask
    // pending order {ext1, ext0, port change, timer}
    task automatic drive(input logic [3:0] v);
        @(posedge clk);
        pend <= v;
    endtask
endmodule

// [testbench/tb_interrupt_enable_mask.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_interrupt_enable_mask;
    import irq_mask_pkg::*;
    logic        clk, arst_n, hsel, hwrite, hreadyout, hresp;
    logic        on, off, vreq, wreq, gen, irq;
    logic [31:0] haddr, hwdata, hrdata, rd, d;
    logic [1:0]  htrans;
    logic [3:0]  pend;
    int          error_cnt, tests_run, mask_m, glob_m, p, en, c;
    irq_core_model i_irq_core_model (.clk(clk), .global_irq_on_instr(on),
        .global_irq_off_instr(off), .pend(pend));
    interrupt_enable_mask i_interrupt_enable_mask (.clk(clk), .arst_n(arst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .global_irq_on_instr(on), .global_irq_off_instr(off), .ext_pin0_pending(pend[2]),
        .ext_pin1_pending(pend[3]), .port_change_pending(pend[1]),
        .timer_overflow_pending(pend[0]), .irq_vector_req(vreq), .wake_req(wreq),
        .global_irq_enable(gen), .irq(irq));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= {20'h00000, a};
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // level outputs are registered, three edges leave margin
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("tests %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        arst_n = 1'b0;
        hsel   = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr  = 32'h0;
        hwdata = 32'h0;
        mask_m = 0;
        glob_m = 0;
        p      = 0;
        void'($urandom(32'h9711));
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        bus(1'b0, ADDR_MASK, 32'h0);
        `CHK("mask reset", 0, rd)
        bus(1'b0, 12'h020, 32'h0);
        `CHK("unmapped", 0, rd)
        `CHK("hresp", 1'b0, hresp)
        $display("reset test done");
        for (int i = 0; i < 12; i++) begin
            d = $urandom();
            bus(1'b1, ADDR_MASK, d);
            mask_m = d & MASK_IMPL;
            bus(1'b0, ADDR_MASK, 32'h0);
            `CHK("mask rd", mask_m, rd)
            p = $urandom() & 4'hF;
            c = $urandom() & 3;
            i_irq_core_model.drive(p[3:0]);
            i_irq_core_model.instr(c[1:0]);
            if (c != 0)
                glob_m = (c == 1);
            settle();
            en = {mask_m[2], mask_m[2], mask_m[1], mask_m[0]};
            `CHK("wake", (p & en) != 0, wreq)
            `CHK("vector", (p & en) != 0 && glob_m, vreq)
            `CHK("global", glob_m, gen)
            bus(1'b0, ADDR_PENDING, 32'h0);
            `CHK("pending", p, rd)
        end
        $display("mask test done");
        // port change needs its enable before relying on it
        i_irq_core_model.drive(4'h0);
        i_irq_core_model.instr(2'h2);
        bus(1'b1, ADDR_MASK, 32'h2);
        bus(1'b1, ADDR_IRQ_ENABLE, 32'h3);
        bus(1'b1, ADDR_IRQ_CLEAR, 32'h3);
        settle();
        `CHK("irq idle", 1'b0, irq)
        i_irq_core_model.drive(4'h2);
        settle();
        bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
        `CHK("status wake", 2, rd)
        `CHK("irq set", 1'b1, irq)
        bus(1'b1, ADDR_IRQ_CLEAR, 32'h2);
        settle();
        `CHK("irq clr", 1'b0, irq)
        bus(1'b1, ADDR_IRQ_ENABLE, 32'h0);
        i_irq_core_model.instr(2'h1);
        settle();
        bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
        `CHK("status vec", 1, rd)
        `CHK("irq masked", 1'b0, irq)
        $display("event test done");
        tally_and_finish();
    end
endmodule
